// *** rtl/i2cm_defines.vh ***
// i2cm_defines.vh - command codes, field widths and bus timing of the i2c master
// assumes: included by bare name from the design files under rtl/
`ifndef I2CM_DEFINES_VH
`define I2CM_DEFINES_VH

`define I2CM_CMD_READ 2'h1
`define I2CM_CMD_WRITE 2'h2
`define I2CM_CMD_STOP 2'h3

`define I2CM_IDX_W 9
`define I2CM_MEM_DEPTH 512

// direction bit that follows the target address
`define I2CM_RW_READ 1'b1
`define I2CM_RW_WRITE 1'b0

// bit position of the ninth (acknowledge) clock within a byte
`define I2CM_ACK_BIT 4'h8

`define I2CM_CLK_NS 40
`define I2CM_SCL_NS 320
// one scl period is four quarters; rounds down, never below one
`define I2CM_QTR_CYC ((`I2CM_SCL_NS / (4 * `I2CM_CLK_NS)) < 1 ? 1 : \
   (`I2CM_SCL_NS / (4 * `I2CM_CLK_NS)))

`endif

// *** rtl/i2cm_buf2.v ***
// i2cm_buf2.v - two-entry valid/ready buffer for received bytes
// assumes: single clock mclk, asynchronous active-low reset
`timescale 1ns/10ps
module i2cm_buf2 (
   input wire mclk,
   input wire reset_n,
   input wire inValid,
   input wire [7:0] inData,
   output wire inReady,
   output wire outValid,
   output wire [7:0] outData,
   input wire outReady
);
   reg [7:0] d0_ff;
   reg [7:0] d1_ff;
   reg v0_ff;
   reg v1_ff;
   wire pop;
   wire push;

   assign inReady = ~v1_ff;
   assign outValid = v0_ff;
   assign outData = d0_ff;
   assign pop = v0_ff & outReady;
   assign push = inValid & ~v1_ff;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         d0_ff <= 8'h00;
         d1_ff <= 8'h00;
         v0_ff <= 1'b0;
         v1_ff <= 1'b0;
      end else if (pop) begin
         if (v1_ff) begin
            d0_ff <= d1_ff;
            v0_ff <= 1'b1;
            v1_ff <= push;
            if (push) begin
               d1_ff <= inData;
            end
         end else begin
            d0_ff <= inData;
            v0_ff <= push;
         end
      end else if (push) begin
         if (!v0_ff) begin
            d0_ff <= inData;
            v0_ff <= 1'b1;
         end else begin
            d1_ff <= inData;
            v1_ff <= 1'b1;
         end
      end
   end
endmodule // i2cm_buf2

// *** rtl/i2cm_engine.v ***
// i2cm_engine.v - i2c master command engine with its own data memory array
// assumes: scl/sda are open-drain with external pull-ups; sdaIn is asynchronous
`timescale 1ns/10ps
`include "i2cm_defines.vh"
module i2cm_engine (
   input wire mclk,
   input wire reset_n,
   input wire cmdValid,
   input wire [1:0] cmdCode,
   input wire [6:0] cmdTarget,
   input wire [`I2CM_IDX_W-1:0] cmdStart,
   input wire [`I2CM_IDX_W-1:0] cmdCount,
   output reg busy_ff,
   output reg ackOk_ff,
   input wire memWe,
   input wire [`I2CM_IDX_W-1:0] memAddr,
   input wire [7:0] memWdata,
   output reg [7:0] memRdata_ff,
   output wire rxValid,
   output wire [7:0] rxData,
   input wire rxReady,
   output reg sclOut_ff,
   output reg sclOe_ff,
   input wire sdaIn,
   output reg sdaOut_ff,
   output reg sdaOe_ff
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_BIT = 3'h2;
   localparam [2:0] ST_HOLD = 3'h3;
   localparam [2:0] ST_STOP = 3'h4;
   localparam [2:0] ST_DRAIN = 3'h5;
   // quarter length fits four bits; cut on purpose from the integer count
   localparam integer QTR_CYC = `I2CM_QTR_CYC;
   localparam [3:0] QTR_LAST = QTR_CYC[3:0] - 4'h1;

   reg [7:0] dataMem [0:`I2CM_MEM_DEPTH-1];
   reg [2:0] state_ff;
   reg [1:0] phase_ff;
   reg [3:0] qCnt_ff;
   reg [3:0] bitCnt_ff;
   reg [7:0] shift_ff;
   reg rw_ff;
   reg isAddr_ff;
   reg open_ff;
   reg [`I2CM_IDX_W-1:0] idx_ff;
   reg [`I2CM_IDX_W-1:0] wrIdx_ff;
   reg [`I2CM_IDX_W-1:0] remain_ff;
   reg pushValid_ff;
   reg [7:0] pushData_ff;
   reg sdaS1_ff;
   reg sdaS2_ff;
   reg sdaS3_ff;
   reg sdaSync_ff;
   reg nxt_sclOe;
   reg nxt_sdaOe;
   reg bitVal;
   wire tick;
   wire rxByte;
   wire ackBit;
   wire bufReady;
   wire stall;
   wire adv;
   wire pop;

   assign tick = (qCnt_ff == QTR_LAST);
   assign rxByte = (rw_ff == `I2CM_RW_READ) & ~isAddr_ff;
   assign ackBit = (bitCnt_ff == `I2CM_ACK_BIT);
   // hold scl low before the ack of a read byte until the buffer has room
   assign stall = (state_ff == ST_BIT) & ackBit & rxByte & (phase_ff == 2'h0) & ~bufReady;
   assign adv = tick & ~stall;
   assign pop = rxValid & rxReady;

   i2cm_buf2 rxBuf (
      .mclk(mclk),
      .reset_n(reset_n),
      .inValid(pushValid_ff),
      .inData(pushData_ff),
      .inReady(bufReady),
      .outValid(rxValid),
      .outData(rxData),
      .outReady(rxReady)
   );

   // host port writes only while idle; received bytes land as they leave the buffer
   always @(posedge mclk) begin
      if (pop) begin
         dataMem[wrIdx_ff] <= rxData;
      end else if (memWe && !busy_ff) begin
         dataMem[memAddr] <= memWdata;
      end
      memRdata_ff <= dataMem[memAddr];
   end

   always @* begin
      bitVal = 1'b1;
      if (!ackBit) begin
         bitVal = rxByte ? 1'b1 : shift_ff[7];
      end else if (rxByte) begin
         bitVal = (remain_ff == 9'h001);
      end
      nxt_sclOe = 1'b0;
      nxt_sdaOe = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            nxt_sclOe = open_ff;
         end
         ST_START: begin
            nxt_sclOe = (phase_ff == 2'h0) | (phase_ff == 2'h3);
            nxt_sdaOe = phase_ff[1];
         end
         ST_BIT: begin
            nxt_sclOe = ~phase_ff[1];
            nxt_sdaOe = (phase_ff == 2'h0) ? sdaOe_ff : ~bitVal;
         end
         ST_HOLD: begin
            nxt_sclOe = 1'b1;
         end
         ST_STOP: begin
            nxt_sclOe = ~phase_ff[1];
            nxt_sdaOe = (phase_ff == 2'h0) ? sdaOe_ff : (phase_ff != 2'h3);
         end
         default: begin
            nxt_sclOe = 1'b0;
            nxt_sdaOe = 1'b0;
         end
      endcase
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         phase_ff <= 2'h0;
         qCnt_ff <= 4'h0;
         bitCnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         rw_ff <= 1'b0;
         isAddr_ff <= 1'b0;
         open_ff <= 1'b0;
         idx_ff <= {`I2CM_IDX_W{1'b0}};
         wrIdx_ff <= {`I2CM_IDX_W{1'b0}};
         remain_ff <= {`I2CM_IDX_W{1'b0}};
         pushValid_ff <= 1'b0;
         pushData_ff <= 8'h00;
         sdaS1_ff <= 1'b1;
         sdaS2_ff <= 1'b1;
         sdaS3_ff <= 1'b1;
         sdaSync_ff <= 1'b1;
         busy_ff <= 1'b0;
         ackOk_ff <= 1'b0;
         sclOut_ff <= 1'b0;
         sclOe_ff <= 1'b0;
         sdaOut_ff <= 1'b0;
         sdaOe_ff <= 1'b0;
      end else begin
         sdaS1_ff <= sdaIn;
         sdaS2_ff <= sdaS1_ff;
         sdaS3_ff <= sdaS2_ff;
         if (sdaS2_ff == sdaS3_ff) begin
            sdaSync_ff <= sdaS3_ff;
         end
         qCnt_ff <= tick ? 4'h0 : qCnt_ff + 4'h1;
         sclOut_ff <= 1'b0;
         sdaOut_ff <= 1'b0;
         sclOe_ff <= nxt_sclOe;
         sdaOe_ff <= nxt_sdaOe;
         pushValid_ff <= 1'b0;
         if (pop) begin
            wrIdx_ff <= wrIdx_ff + 9'h001;
         end
         if (state_ff == ST_IDLE) begin
            if (cmdValid && !busy_ff && cmdCode != 2'h0) begin
               busy_ff <= 1'b1;
               phase_ff <= 2'h0;
               bitCnt_ff <= 4'h0;
               isAddr_ff <= 1'b1;
               idx_ff <= cmdStart;
               wrIdx_ff <= cmdStart;
               remain_ff <= cmdCount;
               if (cmdCode == `I2CM_CMD_STOP) begin
                  state_ff <= ST_STOP;
               end else begin
                  rw_ff <= (cmdCode == `I2CM_CMD_READ);
                  shift_ff <= {cmdTarget, (cmdCode == `I2CM_CMD_READ)};
                  state_ff <= ST_START;
               end
            end
         end else if (state_ff == ST_DRAIN) begin
            // busy holds until every read byte has left the buffer
            if (!pushValid_ff && !rxValid) begin
               busy_ff <= 1'b0;
               state_ff <= ST_IDLE;
            end
         end else if (adv) begin
            phase_ff <= phase_ff + 2'h1;
            if (state_ff == ST_BIT && ackBit && rxByte && phase_ff == 2'h0) begin
               pushValid_ff <= 1'b1;
               pushData_ff <= shift_ff;
            end
            if (phase_ff == 2'h3) begin
               case (state_ff)
                  ST_START: begin
                     state_ff <= ST_BIT;
                  end
                  ST_BIT: begin
                     if (!ackBit) begin
                        shift_ff <= {shift_ff[6:0], rxByte ? sdaSync_ff : 1'b0};
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                     end else begin
                        bitCnt_ff <= 4'h0;
                        if (rxByte) begin
                           remain_ff <= remain_ff - 9'h001;
                           if (remain_ff == 9'h001) begin
                              state_ff <= ST_STOP;
                           end
                        end else if (sdaSync_ff) begin
                           ackOk_ff <= 1'b0;
                           state_ff <= ST_STOP;
                        end else begin
                           ackOk_ff <= 1'b1;
                           isAddr_ff <= 1'b0;
                           if (rw_ff == `I2CM_RW_READ) begin
                              if (remain_ff == 9'h000) begin
                                 state_ff <= ST_STOP;
                              end
                           end else if (remain_ff == 9'h000) begin
                              state_ff <= ST_HOLD;
                           end else begin
                              shift_ff <= dataMem[idx_ff];
                              idx_ff <= idx_ff + 9'h001;
                              remain_ff <= remain_ff - 9'h001;
                           end
                        end
                     end
                  end
                  ST_HOLD: begin
                     // scl stays low so a read or a stop can follow
                     open_ff <= 1'b1;
                     busy_ff <= 1'b0;
                     state_ff <= ST_IDLE;
                  end
                  ST_STOP: begin
                     open_ff <= 1'b0;
                     state_ff <= ST_DRAIN;
                  end
                  default: begin
                     state_ff <= ST_IDLE;
                  end
               endcase
            end
         end
      end
   end
endmodule // i2cm_engine

// *** dv/i2cm_engine_chk.sv ***
// i2cm_engine_chk.sv - assertions on the i2c master engine ports
// assumes: bound to i2cm_engine, one clock mclk
`timescale 1ns/10ps
module i2cm_engine_chk (
   input wire mclk,
   input wire reset_n,
   input wire cmdValid,
   input wire [1:0] cmdCode,
   input wire busy_ff,
   input wire rxValid,
   input wire [7:0] rxData,
   input wire rxReady,
   input wire sclOut_ff,
   input wire sclOe_ff,
   input wire sdaOut_ff,
   input wire sdaOe_ff
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence s_offer; cmdValid && cmdCode != 2'h0 && !busy_ff; endsequence
   sequence s_stop; $fell(sdaOe_ff) && !sclOe_ff; endsequence
   property p_take; s_offer |=> busy_ff; endproperty
   a_take: assert property (p_take) else $error("command not taken");
   property p_idle; !busy_ff && !(cmdValid && cmdCode != 2'h0) |=> !busy_ff; endproperty
   a_idle: assert property (p_idle) else $error("busy without command");
   property p_rel; !busy_ff [*2] |-> !sdaOe_ff; endproperty
   a_rel: assert property (p_rel) else $error("sda held idle");
   property p_start; $rose(sdaOe_ff) && !sclOe_ff |-> ##[1:4] sclOe_ff; endproperty
   a_start: assert property (p_start) else $error("no clock after start");
   property p_stop; s_stop |=> !sdaOe_ff && !sclOe_ff; endproperty
   a_stop: assert property (p_stop) else $error("bus taken after stop");
   property p_od; !sclOut_ff && !sdaOut_ff; endproperty
   a_od: assert property (p_od) else $error("line driven high");
   property p_rx; rxValid && !rxReady |=> rxValid && $stable(rxData); endproperty
   a_rx: assert property (p_rx) else $error("rx byte lost");
   property p_scl; !busy_ff && !$past(busy_ff) |-> $stable(sclOe_ff); endproperty
   a_scl: assert property (p_scl) else $error("clock moved idle");
endmodule // i2cm_engine_chk
bind i2cm_engine i2cm_engine_chk chk (.mclk(mclk), .reset_n(reset_n), .cmdValid(cmdValid),
   .cmdCode(cmdCode), .busy_ff(busy_ff), .rxValid(rxValid), .rxData(rxData),
   .rxReady(rxReady), .sclOut_ff(sclOut_ff), .sclOe_ff(sclOe_ff), .sdaOut_ff(sdaOut_ff),
   .sdaOe_ff(sdaOe_ff));

// *** dv/i2cm_eeprom_model.sv ***
// i2cm_eeprom_model.sv - behavioural serial eeprom slave
// assumes: scl and sda are resolved open-drain lines with pull-ups
`timescale 1ns/10ps
module i2cm_eeprom_model (
   input wire scl,
   input wire sda,
   output reg pull
);
   // limitation: all four banks share one array and pointer
   reg [7:0] mem [0:65535];
   reg [15:0] ptr = 16'h0000;
   reg [7:0] sh = 8'h00;
   reg [3:0] bc = 4'h0;
   reg [2:0] ph = 3'h4;
   reg rd = 1'b0;
   initial pull = 1'b0;
   always @(negedge sda) if (scl) begin
      bc = 4'h0;
      ph = 3'h0;
   end
   always @(posedge sda) if (scl) ph = 3'h4;
   always @(posedge scl) begin
      if (bc < 4'h8) sh = {sh[6:0], sda};
      else if (rd && sda) ph = 3'h4;
      bc = bc + 4'h1;
   end
   // line changes only while scl is low, so no false start or stop
   always @(negedge scl) begin
      if (bc == 4'h9) bc = 4'h0;
      pull = 1'b0;
      if (bc == 4'h8 && ph == 3'h0) begin
         rd = sh[0];
         ph = sh[7:3] == 5'h14 ? 3'h1 + {sh[0], 1'b0} : 3'h4;
         pull = ph != 3'h4;
      end else if (bc == 4'h8 && rd) ptr = ptr + 16'h1;
      else if (bc == 4'h8 && ph < 3'h4) begin
         if (ph == 3'h1) ptr[15:8] = sh;
         if (ph == 3'h2) ptr[7:0] = sh;
         if (ph == 3'h3) mem[ptr] = sh;
         if (ph == 3'h3) ptr[7:0] = ptr[7:0] + 8'h1;
         else ph = ph + 3'h1;
         pull = 1'b1;
      end else if (rd && ph == 3'h3) pull = !mem[ptr][3'h7 - bc[2:0]];
   end
endmodule // i2cm_eeprom_model

// *** dv/i2c_master_eeprom_access_bench.sv ***
// i2c_master_eeprom_access_bench.sv - directed bench of the i2c master engine
// assumes: eeprom model on the lines; released lines read high
`timescale 1ns/10ps
`include "i2cm_defines.vh"
module i2c_master_eeprom_access_bench;
   reg mclk = 1'b0;
   reg reset_n = 1'b0;
   reg cmdValid = 1'b0;
   reg [1:0] cmdCode = 2'h0;
   reg [6:0] cmdTarget = 7'h00;
   reg [8:0] cmdStart = 9'h000;
   reg [8:0] cmdCount = 9'h000;
   reg memWe = 1'b0;
   reg [8:0] memAddr = 9'h000;
   reg [7:0] memWdata = 8'h00;
   reg rxReady = 1'b1;
   wire busy, ackOk, rxValid, sclOe, sdaOe, pull;
   wire [7:0] memRdata, rxData;
   wire scl = !sclOe;
   wire sda = !(sdaOe || pull);
   int nMismatch = 0, nCompared = 0, nStop = 0, nRise = 0, cyc = 0;
   reg [7:0] q [$];
   reg [7:0] pg [0:5] = '{8'h4d, 8'ha4, 8'h11, 8'h22, 8'h33, 8'h44};
   always #20 mclk = !mclk;
   i2cm_engine dut (.mclk(mclk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
      .cmdTarget(cmdTarget), .cmdStart(cmdStart), .cmdCount(cmdCount), .busy_ff(busy),
      .ackOk_ff(ackOk), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata_ff(memRdata), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
      .sclOut_ff(), .sclOe_ff(sclOe), .sdaIn(sda), .sdaOut_ff(), .sdaOe_ff(sdaOe));
   i2cm_eeprom_model em (.scl(scl), .sda(sda), .pull(pull));
   always @(posedge sda) if (scl) nStop++;
   always @(posedge scl) nRise++;
   always @(posedge mclk) begin
      if (rxValid && rxReady) q.push_back(rxData);
      cyc++;
      if (cyc == 30000) begin
         nMismatch++;
         wrapUp();
      end
   end
   task chk(input string w, input [15:0] e, input [15:0] g);
      nCompared++;
      if (g !== e) begin
         nMismatch++;
         $display("[FAIL] %s expected %h seen %h", w, e, g);
      end
   endtask
   task wrapUp;
      if (nMismatch == 0 && nCompared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task ld(input [8:0] a, input [7:0] v);
      @(posedge mclk);
      memWe <= 1'b1;
      memAddr <= a;
      memWdata <= v;
      @(posedge mclk);
      memWe <= 1'b0;
   endtask
   task cmd(input [1:0] c, input [6:0] t, input [8:0] s, input [8:0] n);
      @(posedge mclk);
      cmdValid <= 1'b1;
      cmdCode <= c;
      cmdTarget <= t;
      cmdStart <= s;
      cmdCount <= n;
      @(posedge mclk);
      cmdValid <= 1'b0;
      @(posedge mclk);
   endtask
   task idle;
      while (busy !== 1'b0) @(posedge mclk);
   endtask
   // two-byte read: 1 start + 9 address + 18 data + 1 stop clock rises
   task rdx(input [8:0] s, input [7:0] a, input [7:0] b);
      int r, p;
      r = nRise;
      p = nStop;
      q.delete();
      cmd(`I2CM_CMD_READ, 7'h50, s, 9'h002);
      idle;
      chk("clocks", 16'h001d, r + 29 == nRise ? 16'h001d : nRise - r);
      chk("stops", p + 1, nStop);
      chk("byte0", a, q[0]);
      chk("byte1", b, q[1]);
   endtask
   task scWrite;
      int p;
      p = nStop;
      cmd(`I2CM_CMD_WRITE, 7'h50, 9'h00b, 9'h006);
      cmdValid <= 1'b1;
      cmdCode <= `I2CM_CMD_STOP;
      repeat (4) @(posedge mclk);
      cmdValid <= 1'b0;
      idle;
      chk("ack", 16'h0001, ackOk);
      chk("open", p, nStop);
      chk("page", 16'h0044, em.mem[16'h4da7]);
      cmd(`I2CM_CMD_STOP, 7'h00, 9'h000, 9'h000);
      idle;
      chk("stop", p + 1, nStop);
   endtask
   task scRead;
      cmd(`I2CM_CMD_WRITE, 7'h50, 9'h00b, 9'h002);
      idle;
      rdx(9'h015, 8'h11, 8'h22);
      @(posedge mclk);
      memAddr <= 9'h016;
      repeat (2) @(posedge mclk);
      chk("stored", 16'h0022, memRdata);
      rdx(9'h017, 8'h33, 8'h44);
   endtask
   task scStall;
      int p;
      cmd(`I2CM_CMD_WRITE, 7'h50, 9'h00b, 9'h002);
      idle;
      p = nStop;
      q.delete();
      rxReady <= 1'b0;
      cmd(`I2CM_CMD_READ, 7'h50, 9'h020, 9'h003);
      repeat (600) @(posedge mclk);
      chk("held", p, nStop);
      chk("busy", 16'h0001, busy);
      rxReady <= 1'b1;
      idle;
      chk("third", 16'h0033, q[2]);
   endtask
   task scNak;
      int p;
      p = nStop;
      cmd(2'h0, 7'h50, 9'h00b, 9'h002);
      chk("noCmd", 16'h0000, busy);
      chk("noCmdStop", p, nStop);
      cmd(`I2CM_CMD_WRITE, 7'h30, 9'h00b, 9'h002);
      idle;
      chk("nak", 16'h0000, ackOk);
      chk("nakStop", p + 1, nStop);
      cmd(`I2CM_CMD_WRITE, 7'h53, 9'h00b, 9'h000);
      idle;
      chk("ack3", 16'h0001, ackOk);
      cmd(`I2CM_CMD_STOP, 7'h00, 9'h000, 9'h000);
      idle;
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      chk("rstBusy", 16'h0000, busy);
      for (int i = 0; i < 6; i++) ld(9'h00b + i[8:0], pg[i]);
      scWrite;
      scRead;
      scStall;
      scNak;
      wrapUp;
   end
endmodule // i2c_master_eeprom_access_bench
